// file: rtl/anpt_pkg.sv
// package: register map, field layout and types of the next page transmit word
package anpt_pkg;
    localparam logic [11:0] ANPT_NEXT_PAGE_TRANSMIT_WORD_ADDR = 12'h0E8;
    // software-side page source registers, placed after the transmit word
    localparam logic [11:0] ANPT_PAGE_LOAD_ADDR = 12'h0F0;
    localparam logic [11:0] ANPT_BASE_TOGGLE_ADDR = 12'h0F4;
    localparam int ANPT_MORE_POS = 15;
    localparam int ANPT_RSVD_POS = 14;
    localparam int ANPT_MSG_POS = 13;
    localparam int ANPT_COMPLY_ACK_FLAG_POS = 12;
    localparam int ANPT_TOGGLE_POS = 11;
    localparam int ANPT_CODE_W = 11;
    localparam logic ANPT_MORE_RST = 1'b0;
    localparam logic ANPT_MSG_RST = 1'b1;
    localparam logic ANPT_COMPLY_ACK_FLAG_RST = 1'b0;
    localparam logic ANPT_TOGGLE_RST = 1'b0;
    localparam logic [10:0] ANPT_CODE_RST = 11'h001;

    typedef struct packed {
        logic morePagesFlag;
        logic messagePageFlag;
        logic complyAckFlag;
        logic [10:0] code;
    } anpt_page_t;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } anpt_apb_req_t;

    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } anpt_apb_rsp_t;
endpackage

// file: rtl/anpt_toggle.sv
// toggle tracker: loads the inverse of the base toggle bit on a base load, else flips it once per exchanged next page
`timescale 1ns/1ns
module anpt_toggle (
    input wire logic clk, // system clock
    input wire logic rst_b, // async reset, active low
    input wire logic baseLoad, // base word toggle captured
    input wire logic baseToggle, // bit 11 of base link code word
    input wire logic pageSent, // one page exchanged
    output logic toggleBit // toggle of current page
);
    import anpt_pkg::*;
    typedef struct packed {
        logic toggle;
    } anpt_tog_state_t;
    anpt_tog_state_t state;
    anpt_tog_state_t next_state;

    always_comb begin
        next_state = state;
        if (baseLoad) begin
            next_state.toggle = ~baseToggle;
        end else if (pageSent) begin
            next_state.toggle = ~state.toggle;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state <= '{toggle: ANPT_TOGGLE_RST};
        end else begin
            state <= next_state;
        end
    end

    assign toggleBit = state.toggle;
endmodule // anpt_toggle

// file: rtl/anpt_regs.sv
// apb register slave holding the port 2 next page transmit word
`timescale 1ns/1ns

// Summary of operation
// - bit 15 set while more pages follow
// - bit 13 message page, resets to one
// - bit 12 shows ability to comply
// - toggle inverts each page exchanged in a cycle without a base load
// - first toggle inverts base word bit 11
// - bits 10:0 code field, resets 0x001
module anpt_regs (
    input wire logic clk, // system clock, 50 MHz
    input wire logic rst_b, // async reset, active low
    input wire anpt_pkg::anpt_apb_req_t apbReq, // apb request
    output anpt_pkg::anpt_apb_rsp_t apbRsp, // apb answer, registered
    input wire logic pageSent, // pulse: page exchanged
    output logic [15:0] nextPageTransmitWord // word to the link
);
    import anpt_pkg::*;

    typedef struct packed {
        anpt_page_t page;
        anpt_apb_rsp_t rsp;
        logic [15:0] word;
    } anpt_state_t;

    anpt_state_t state;
    anpt_state_t next_state;
    logic toggleBit;
    logic baseLoad;
    logic setup;
    logic [15:0] wordNow;

    ////////////////////////////////////////////////////////////////
    assign setup = apbReq.psel && !apbReq.penable;
    assign baseLoad = setup && apbReq.pwrite
        && apbReq.paddr == ANPT_BASE_TOGGLE_ADDR;

    anpt_toggle u_toggle (
        .clk(clk),
        .rst_b(rst_b),
        .baseLoad(baseLoad),
        .baseToggle(apbReq.pwdata[ANPT_TOGGLE_POS]),
        .pageSent(pageSent),
        .toggleBit(toggleBit)
    );

    always_comb begin
        wordNow = 16'h0000;
        wordNow[ANPT_MORE_POS] = state.page.morePagesFlag;
        wordNow[ANPT_MSG_POS] = state.page.messagePageFlag;
        wordNow[ANPT_COMPLY_ACK_FLAG_POS] = state.page.complyAckFlag;
        wordNow[ANPT_TOGGLE_POS] = toggleBit;
        wordNow[ANPT_CODE_W-1:0] = state.page.code;
    end

    ////////////////////////////////////////////////////////////////
    // answer one cycle after setup: ready rises in the access phase
    always_comb begin
        next_state = state;
        next_state.word = wordNow;
        next_state.rsp.pready = 1'b0;
        next_state.rsp.pslverr = 1'b0;
        if (setup) begin
            next_state.rsp.pready = 1'b1;
            next_state.rsp.prdata = 32'h0000_0000;
            unique case (apbReq.paddr)
                ANPT_NEXT_PAGE_TRANSMIT_WORD_ADDR: begin
                    // read-only: write accepted, no effect
                    if (!apbReq.pwrite) begin
                        next_state.rsp.prdata = {16'h0000, wordNow};
                    end
                end
                ANPT_PAGE_LOAD_ADDR: begin
                    if (apbReq.pwrite) begin
                        next_state.page.morePagesFlag =
                            apbReq.pwdata[ANPT_MORE_POS];
                        next_state.page.messagePageFlag =
                            apbReq.pwdata[ANPT_MSG_POS];
                        next_state.page.complyAckFlag =
                            apbReq.pwdata[ANPT_COMPLY_ACK_FLAG_POS];
                        next_state.page.code =
                            apbReq.pwdata[ANPT_CODE_W-1:0];
                    end else begin
                        next_state.rsp.prdata = {16'h0000,
                            state.page.morePagesFlag, 1'b0,
                            state.page.messagePageFlag,
                            state.page.complyAckFlag, 1'b0,
                            state.page.code};
                    end
                end
                ANPT_BASE_TOGGLE_ADDR: begin
                    if (!apbReq.pwrite) begin
                        next_state.rsp.prdata = {20'h00000, toggleBit,
                            11'h000};
                    end
                end
                default: begin
                    next_state.rsp.pslverr = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state.page.morePagesFlag <= ANPT_MORE_RST;
            state.page.messagePageFlag <= ANPT_MSG_RST;
            state.page.complyAckFlag <= ANPT_COMPLY_ACK_FLAG_RST;
            state.page.code <= ANPT_CODE_RST;
            state.rsp <= '0;
            state.word <= {ANPT_MORE_RST, 1'b0, ANPT_MSG_RST,
                ANPT_COMPLY_ACK_FLAG_RST, ANPT_TOGGLE_RST, ANPT_CODE_RST};
        end else begin
            state <= next_state;
        end
    end

    assign apbRsp = state.rsp;
    assign nextPageTransmitWord = state.word;
endmodule // anpt_regs

// file: test/anpt_regs_asserts.sv
// checker for the next page transmit word register
`timescale 1ns/1ns
module anpt_regs_asserts (
    input wire logic clk, // system clock
    input wire logic rst_b, // async reset, active low
    input wire anpt_pkg::anpt_apb_req_t apbReq, // apb request
    input wire anpt_pkg::anpt_apb_rsp_t apbRsp, // apb answer
    input wire logic pageSent, // page exchanged pulse
    input wire logic [15:0] nextPageTransmitWord // word to the link
);
    import anpt_pkg::*;
    default clocking dc @(posedge clk); endclocking
    default disable iff (!rst_b);
    logic su;
    logic [15:0] w;
    assign su = apbReq.psel & !apbReq.penable;
    assign w = nextPageTransmitWord;
    a_rsvd_zero: assert property (w[14] == 1'b0)
        else $error("reserved bit set");
    a_reset_word: assert property ($rose(rst_b) |-> w == 16'h2001)
        else $error("wrong word after reset");
    // a base load at the same time would win, so leave it out
    a_toggle_flip: assert property (pageSent && !(su &&
        apbReq.paddr == ANPT_BASE_TOGGLE_ADDR) |-> ##2 w[11] != $past(w[11]))
        else $error("toggle did not flip");
    a_ready_next: assert property (su |=> apbRsp.pready)
        else $error("no answer after setup");
    a_ready_pulse: assert property (apbRsp.pready |=> !apbRsp.pready)
        else $error("ready held too long");
    a_read_word: assert property (apbRsp.pready && !apbReq.pwrite &&
        apbReq.paddr == ANPT_NEXT_PAGE_TRANSMIT_WORD_ADDR
        |-> apbRsp.prdata == {16'h0000, w})
        else $error("read data differs from word");
    a_err_map: assert property (su && apbReq.paddr != ANPT_PAGE_LOAD_ADDR &&
        apbReq.paddr != ANPT_BASE_TOGGLE_ADDR &&
        apbReq.paddr != ANPT_NEXT_PAGE_TRANSMIT_WORD_ADDR |=> apbRsp.pslverr)
        else $error("unmapped access not refused");
endmodule // anpt_regs_asserts

bind anpt_regs anpt_regs_asserts chkI (.clk(clk), .rst_b(rst_b),
    .apbReq(apbReq), .apbRsp(apbRsp), .pageSent(pageSent),
    .nextPageTransmitWord(nextPageTransmitWord));

// file: test/anpt_link_partner.sv
// link partner model: answers each request with one page exchange
`timescale 1ns/1ns
module anpt_link_partner (
    input wire logic clk, // system clock
    input wire logic rst_b, // async reset, active low
    input wire logic [2:0] gap, // answer delay, 0 is prompt
    input wire logic go, // start one exchange
    output logic pageSent // one-cycle exchange pulse
);
    logic [7:0] sh;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) sh <= 8'h00;
        else sh <= {sh[6:0], go};
    end
    assign pageSent = sh[gap];
endmodule // anpt_link_partner

// file: test/anpt_regs_test.sv
// testbench for the next page transmit word register
`timescale 1ns/1ns
module anpt_regs_test;
    import anpt_pkg::*;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic go = 1'b0;
    logic [2:0] gap = 3'h0;
    logic pageSent;
    logic [15:0] word;
    logic [31:0] rd;
    logic err;
    anpt_apb_req_t req = '0;
    anpt_apb_rsp_t rsp;
    int fails = 0;
    int nTests = 0;
    int cyc = 0;
    always #10 clk = ~clk;
    anpt_regs uut (.clk(clk), .rst_b(rst_b), .apbReq(req), .apbRsp(rsp),
        .pageSent(pageSent), .nextPageTransmitWord(word));
    anpt_link_partner lp (.clk(clk), .rst_b(rst_b), .gap(gap), .go(go),
        .pageSent(pageSent));
    task automatic stopTest();
        $display("checks %0d mismatches %0d", nTests, fails);
        if (fails == 0 && nTests > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        nTests++;
        if (g !== e) begin
            fails++;
            $display("CHECK FAILED %0t got %h want %h", $time, g, e);
        end
    endtask
    task automatic apb(input logic [11:0] a, input logic wr,
        input logic [31:0] d);
        req <= '{1'b1, 1'b0, wr, a, d};
        @(posedge clk);
        req.penable <= 1'b1;
        do @(posedge clk); while (rsp.pready !== 1'b1);
        rd = rsp.prdata;
        err = rsp.pslverr;
        req <= '0;
        // word output trails the register state by a cycle
        repeat (2) @(posedge clk);
    endtask
    task automatic rdw(input logic [15:0] e);
        apb(ANPT_NEXT_PAGE_TRANSMIT_WORD_ADDR, 1'b0, 32'h0000_0000);
        chk(rd, {16'h0000, e});
        chk({16'h0000, word}, {16'h0000, e});
    endtask
    task automatic page(input logic [2:0] g);
        gap <= g;
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        repeat (12) @(posedge clk);
    endtask
    task automatic tFields();
        rdw(16'h2001);
        apb(ANPT_PAGE_LOAD_ADDR, 1'b1, 32'hFFFF_FFFF);
        rdw(16'hB7FF);
        apb(ANPT_PAGE_LOAD_ADDR, 1'b0, 32'h0000_0000);
        chk(rd, 32'h0000_B7FF);
        apb(ANPT_NEXT_PAGE_TRANSMIT_WORD_ADDR, 1'b1, 32'h0000_0000);
        chk({31'h0, err}, 32'h0000_0000);
        rdw(16'hB7FF);
        apb(ANPT_PAGE_LOAD_ADDR, 1'b1, 32'h0000_0000);
        rdw(16'h0000);
        apb(ANPT_NEXT_PAGE_TRANSMIT_WORD_ADDR, 1'b1, 32'hFFFF_FFFF);
        rdw(16'h0000);
        $display("field test done");
    endtask
    task automatic tToggle();
        apb(ANPT_BASE_TOGGLE_ADDR, 1'b1, 32'h0000_0800);
        rdw(16'h0000);
        apb(ANPT_BASE_TOGGLE_ADDR, 1'b1, 32'h0000_0000);
        rdw(16'h0800);
        apb(ANPT_BASE_TOGGLE_ADDR, 1'b0, 32'h0000_0000);
        chk(rd, 32'h0000_0800);
        page(3'h0);
        rdw(16'h0000);
        page(3'h6);
        rdw(16'h0800);
        $display("toggle test done");
    endtask
    task automatic tMap();
        apb(12'h0EC, 1'b0, 32'h0000_0000);
        chk({31'h0, err}, 32'h0000_0001);
        $display("unmapped test done");
    endtask
    initial begin
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        tFields();
        tToggle();
        tMap();
        stopTest();
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 2000) begin
            fails++;
            stopTest();
        end
    end
endmodule // anpt_regs_test
